/* File: irq_arb_pkg.sv */
// Purpose: Shared constants and types for the maskable interrupt arbiter
// Assumes: One 250 MHz clock; registers reached over APB with 32-bit words
// Notes:   Source index 0 is the highest ranked maskable source
//
// Functional notes
// - Thirteen maskable sources, each with a fixed rank and own vector slot.
// - Software trap ranks highest; default vector-select slot ranks lowest.
// - All sources but the trap maskable; own enable and pending bits, software mapped.
// - A source event sets its pending flag regardless of its enable.
// - Trigger needs pending, enable, global enable, and no trap routine running.
// - Triggers are evaluated only at an instruction start.
// - A pending instruction skip is done before an interrupt is acknowledged.
// - Simultaneous qualified sources: highest rank served, others stay pending.
// - Reset clears all pending flags, enables and the global enable.
// - Enabling a source whose flag is set triggers at once; clear flag first.
// - Acknowledge clears global enable, pushes next address, loads PC with 00FF.
// - Acknowledge sequence lasts exactly seven instruction cycles.
// - Software writing 1 to global enable lets sources nest.
// - An event recurring during its routine sets the flag again.
// - Return sets global enable, pops the address; pending requests served next.
// - Vector select jumps through the highest ranked enabled and pending entry; while a trap routine runs the code uses the trap entry (slot F).
// - Vector select with nothing enabled and pending uses the default entry; while a trap routine runs the code uses the trap entry (slot F).
// - Sixteen two-byte vectors at block top, high byte at lower address.
package irq_arb_pkg;

  localparam int          NUM_SRC        = 13;
  localparam int          INSTR_DIV      = 4;
  localparam logic [2:0]  ACK_LAST_TICK  = 3'h6;
  localparam logic [14:0] SERVICE_ADDR   = 15'h00FF;
  localparam logic [3:0]  TRAP_SLOT      = 4'hF;
  localparam logic [3:0]  DEFAULT_SLOT   = 4'h0;
  localparam logic [3:0]  TOP_SRC_SLOT   = 4'hE;
  localparam logic [7:0]  VEC_TABLE_BASE = 8'hE0;

  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  ENABLE_OFS     = 8'h04;
  localparam logic [7:0]  PEND_OFS       = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0C;
  localparam logic [7:0]  VECSEL_OFS     = 8'h10;

  localparam int          CTRL_GIE_BIT   = 0;
  localparam int          STAT_GIE_BIT   = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_TRAPP_BIT = 2;
  localparam int          STAT_NMI_BIT   = 3;

  localparam logic [12:0] ENABLE_RST     = 13'h0000;
  localparam logic [12:0] PEND_RST       = 13'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK  = 2'b01
  } ack_state_t;

endpackage

/* File: tick_divider.sv */
// Purpose: Instruction-cycle enable pulse generator
// Assumes: DIV of at least 2
// Notes:   One-cycle pulse every DIV clocks
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Enable out
  output logic      tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       tick_next;

  always_comb begin
    tick_next = (cnt_reg == 8'(DIV - 1));
    cnt_next  = tick_next ? 8'h00 : cnt_reg + 8'h01;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end
endmodule
`default_nettype wire

/* File: rank_picker.sv */
// Purpose: Fixed-rank picker over a request vector
// Assumes: Index 0 is the highest rank
// Notes:   Purely combinational
`timescale 1ns/1ns
`default_nettype none
module rank_picker #(
  parameter int N = 13
) (
  // Requests
  input  wire logic [N-1:0] req,
  // Winner
  output logic              found,
  output logic [3:0]        idx
);
  logic [N:0]   blocked;
  logic [N-1:0] grant;

  assign blocked[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_rank
      assign grant[g]     = req[g] & ~blocked[g];
      assign blocked[g+1] = blocked[g] | req[g];
    end
  endgenerate

  always_comb begin
    found = blocked[N];
    idx   = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (grant[i]) begin
        idx = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: maskable_interrupt_arbiter.sv */
// Purpose: Pending/enable flags, trigger qualification, acknowledge sequence, vector select
// Assumes: Sequencer and event sources run on CLK; APB slave with one wait state
// Notes:   Instruction cycles are ticks of an internal divider
`timescale 1ns/1ns
`default_nettype none
module maskable_interrupt_arbiter
  import irq_arb_pkg::*;
#(
  parameter int DIV = INSTR_DIV
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Peripheral events
  input  wire logic [12:0] SRC_EVENT,
  // Sequencer requests
  input  wire logic        INSTR_START,
  input  wire logic        SKIP_PENDING,
  input  wire logic        TRAP_EXEC,
  input  wire logic        RETURN_FROM_INTERRUPT_INSTR_EXEC,
  input  wire logic        VIS_EXEC,
  input  wire logic [14:0] NEXT_PC,
  // Sequencer answers
  output logic             ACK_BUSY,
  output logic             PUSH_STB,
  output logic [14:0]      PUSH_ADDR,
  output logic             PC_LOAD_STB,
  output logic [14:0]      PC_LOAD_ADDR,
  output logic             POP_STB,
  output logic             VIS_STB,
  output logic [7:0]       VIS_VEC_ADDR,
  output logic             GIE_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  ack_state_t  state_reg, state_next;
  logic [2:0]  tick_cnt_reg, tick_cnt_next;
  logic        gie_reg, gie_next;
  logic [12:0] enable_reg, enable_next;
  logic [12:0] pend_reg, pend_next;
  logic        trap_pend_reg, trap_pend_next;
  logic        nmi_active_reg, nmi_active_next;
  logic [14:0] push_addr_next;
  logic        push_stb_next, pc_load_stb_next, pop_stb_next;
  logic        vis_stb_next;
  logic [7:0]  vis_vec_next;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next;
  logic        instr_tick;
  logic        qual_found, vis_found;
  logic [3:0]  qual_idx, vis_idx;
  logic        apb_wr, apb_rd, addr_ok;
  logic        boundary, take_trap, take_mask;
  logic [3:0]  vis_slot;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction cycle enable and rank pickers
  tick_divider #(.DIV(DIV)) u_div (
    .clk  (CLK),
    .nrst (NRST),
    .tick (instr_tick)
  );

  rank_picker #(.N(NUM_SRC)) u_qual (
    .req   (pend_reg & enable_reg),
    .found (qual_found),
    .idx   (qual_idx)
  );

  rank_picker #(.N(NUM_SRC)) u_vis (
    .req   (pend_reg & enable_reg),
    .found (vis_found),
    .idx   (vis_idx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode
  always_comb begin
    apb_wr  = PSEL & PENABLE & PREADY & PWRITE;
    apb_rd  = PSEL & PENABLE & ~PREADY & ~PWRITE;
    addr_ok = (PADDR == CTRL_OFS) | (PADDR == ENABLE_OFS) | (PADDR == PEND_OFS) |
              (PADDR == STATUS_OFS) | (PADDR == VECSEL_OFS);
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      CTRL_OFS:   rd_mux[CTRL_GIE_BIT] = gie_reg;
      ENABLE_OFS: rd_mux[12:0] = enable_reg;
      PEND_OFS:   rd_mux[12:0] = pend_reg;
      STATUS_OFS: begin
        rd_mux[STAT_GIE_BIT]   = gie_reg;
        rd_mux[STAT_BUSY_BIT]  = (state_reg == ST_ACK);
        rd_mux[STAT_TRAPP_BIT] = trap_pend_reg;
        rd_mux[STAT_NMI_BIT]   = nmi_active_reg;
      end
      VECSEL_OFS: rd_mux[7:0] = vis_vec_next;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    pready_next  = PSEL & PENABLE & ~PREADY;
    pslverr_next = PSEL & PENABLE & ~PREADY & ~addr_ok;
    prdata_next  = apb_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= pready_next;
      PSLVERR <= pslverr_next;
      PRDATA  <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger qualification
  always_comb begin
    boundary  = INSTR_START & ~SKIP_PENDING & (state_reg == ST_IDLE);
    take_trap = boundary & trap_pend_reg;
    take_mask = boundary & ~trap_pend_reg & qual_found & gie_reg &
                ~nmi_active_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and enables
  always_comb begin
    enable_next = enable_reg;
    if (apb_wr && PADDR == ENABLE_OFS) begin
      enable_next = PWDATA[12:0];
    end
    pend_next = pend_reg;
    if (apb_wr && PADDR == PEND_OFS) begin
      pend_next = pend_reg & ~PWDATA[12:0];
    end
    pend_next = pend_next | SRC_EVENT;
    trap_pend_next = trap_pend_reg;
    if (take_trap) begin
      trap_pend_next = 1'b0;
    end
    if (TRAP_EXEC) begin
      trap_pend_next = 1'b1;
    end
    nmi_active_next = nmi_active_reg;
    if (RETURN_FROM_INTERRUPT_INSTR_EXEC) begin
      nmi_active_next = 1'b0;
    end
    if (take_trap) begin
      nmi_active_next = 1'b1;
    end
    gie_next = gie_reg;
    if (apb_wr && PADDR == CTRL_OFS) begin
      gie_next = PWDATA[CTRL_GIE_BIT];
    end
    if (RETURN_FROM_INTERRUPT_INSTR_EXEC) begin
      gie_next = 1'b1;
    end
    if (take_trap || take_mask) begin
      gie_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      enable_reg     <= ENABLE_RST;
      pend_reg       <= PEND_RST;
      gie_reg        <= 1'b0;
      trap_pend_reg  <= 1'b0;
      nmi_active_reg <= 1'b0;
    end else begin
      enable_reg     <= enable_next;
      pend_reg       <= pend_next;
      gie_reg        <= gie_next;
      trap_pend_reg  <= trap_pend_next;
      nmi_active_reg <= nmi_active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge sequence
  always_comb begin
    state_next       = state_reg;
    tick_cnt_next    = tick_cnt_reg;
    push_addr_next   = PUSH_ADDR;
    push_stb_next    = 1'b0;
    pc_load_stb_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (take_trap || take_mask) begin
          state_next     = ST_ACK;
          tick_cnt_next  = 3'h0;
          push_addr_next = NEXT_PC;
        end
      end
      ST_ACK: begin
        if (instr_tick) begin
          tick_cnt_next = tick_cnt_reg + 3'h1;
          if (tick_cnt_reg == 3'h0) begin
            push_stb_next = 1'b1;
          end
          if (tick_cnt_reg == ACK_LAST_TICK) begin
            pc_load_stb_next = 1'b1;
            state_next       = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 3'h0;
      PUSH_ADDR    <= 15'h0000;
      PUSH_STB     <= 1'b0;
      PC_LOAD_STB  <= 1'b0;
      PC_LOAD_ADDR <= SERVICE_ADDR;
      ACK_BUSY     <= 1'b0;
      GIE_OUT      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      PUSH_ADDR    <= push_addr_next;
      PUSH_STB     <= push_stb_next;
      PC_LOAD_STB  <= pc_load_stb_next;
      PC_LOAD_ADDR <= SERVICE_ADDR;
      ACK_BUSY     <= (state_next == ST_ACK);
      GIE_OUT      <= gie_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Return and vector select
  always_comb begin
    pop_stb_next = RETURN_FROM_INTERRUPT_INSTR_EXEC;
    vis_stb_next = VIS_EXEC;
    if (nmi_active_reg) begin
      vis_slot = TRAP_SLOT;
    end else if (vis_found) begin
      vis_slot = 4'(TOP_SRC_SLOT - vis_idx);
    end else begin
      vis_slot = DEFAULT_SLOT;
    end
    vis_vec_next = VEC_TABLE_BASE | {3'h0, vis_slot, 1'b0};
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      POP_STB      <= 1'b0;
      VIS_STB      <= 1'b0;
      VIS_VEC_ADDR <= VEC_TABLE_BASE;
    end else begin
      POP_STB      <= pop_stb_next;
      VIS_STB      <= vis_stb_next;
      VIS_VEC_ADDR <= vis_stb_next ? vis_vec_next : VIS_VEC_ADDR;
    end
  end

endmodule
`default_nettype wire

/* File: irq_arb_assertions.sv */
// Purpose: Concurrent checks on the arbiter's sequencer-side ports
// Assumes: One clock domain; NRST asynchronous, active low
// Notes:   Bound to every arbiter instance
`timescale 1ns/1ns
`default_nettype none
module irq_arb_checker
  import irq_arb_pkg::*;
#(
  parameter int DIV = INSTR_DIV
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        NRST,
  // Sequencer requests
  input wire logic        INSTR_START,
  input wire logic        SKIP_PENDING,
  input wire logic        RETURN_FROM_INTERRUPT_INSTR_EXEC,
  input wire logic        VIS_EXEC,
  // Sequencer answers
  input wire logic        ACK_BUSY,
  input wire logic        PUSH_STB,
  input wire logic        PC_LOAD_STB,
  input wire logic [14:0] PC_LOAD_ADDR,
  input wire logic        POP_STB,
  input wire logic        VIS_STB,
  input wire logic [7:0]  VIS_VEC_ADDR,
  input wire logic        GIE_OUT
);
  // First to seventh instruction tick, in clocks
  localparam int PUSH_TO_LOAD = 6 * DIV;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////
  a_start_boundary: assert property (
    $rose(ACK_BUSY) |-> $past(INSTR_START) && !$past(SKIP_PENDING))
    else $error("acknowledge began off an instruction start");
  a_ack_gie: assert property ($rose(ACK_BUSY) |-> !GIE_OUT)
    else $error("global enable not cleared on acknowledge");
  a_push_inside: assert property (PUSH_STB |-> ACK_BUSY && !PC_LOAD_STB)
    else $error("push outside acknowledge");
  a_load_service: assert property (
    PC_LOAD_STB |-> PC_LOAD_ADDR == SERVICE_ADDR && $past(ACK_BUSY) && !ACK_BUSY)
    else $error("service load wrong");
  a_ack_length: assert property ($rose(ACK_BUSY) |-> !PC_LOAD_STB[*8] ##[1:40] PC_LOAD_STB)
    else $error("acknowledge length wrong");
  a_push_to_load: assert property (PUSH_STB |-> ##PUSH_TO_LOAD PC_LOAD_STB)
    else $error("service load not six instruction cycles after push");
  a_return_from_interrupt_instr_pop: assert property (
    RETURN_FROM_INTERRUPT_INSTR_EXEC && !INSTR_START && !ACK_BUSY |=> POP_STB && GIE_OUT)
    else $error("return did not pop and enable");
  a_pop_cause: assert property (POP_STB |-> $past(RETURN_FROM_INTERRUPT_INSTR_EXEC))
    else $error("pop without return");
  a_vis_strobe: assert property (VIS_EXEC |=> VIS_STB)
    else $error("vector select not answered");
  a_vis_table: assert property (
    VIS_STB |-> VIS_VEC_ADDR[0] == 1'b0 && VIS_VEC_ADDR[7:5] == 3'h7)
    else $error("vector address outside table");
  c_ack: cover property ($rose(ACK_BUSY));
  c_pop: cover property (POP_STB);
  c_trap_vec: cover property (VIS_STB && VIS_VEC_ADDR == 8'hFE);
endmodule
bind maskable_interrupt_arbiter irq_arb_checker #(.DIV(DIV)) irq_arb_checker_inst (
  .CLK(CLK), .NRST(NRST),
  .INSTR_START(INSTR_START), .SKIP_PENDING(SKIP_PENDING), .RETURN_FROM_INTERRUPT_INSTR_EXEC(RETURN_FROM_INTERRUPT_INSTR_EXEC),
  .VIS_EXEC(VIS_EXEC), .ACK_BUSY(ACK_BUSY), .PUSH_STB(PUSH_STB), .PC_LOAD_STB(PC_LOAD_STB),
  .PC_LOAD_ADDR(PC_LOAD_ADDR), .POP_STB(POP_STB), .VIS_STB(VIS_STB),
  .VIS_VEC_ADDR(VIS_VEC_ADDR), .GIE_OUT(GIE_OUT));
`default_nettype wire

/* File: seq_model.sv */
// Purpose: Instruction sequencer model facing the arbiter
// Assumes: Instruction start every fourth clock outside acknowledge
// Notes:   Counts pushes and keeps the last pushed address
`timescale 1ns/1ns
`default_nettype none
module seq_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Bench control
  input  wire logic        run,
  // Arbiter answers
  input  wire logic        ack_busy,
  input  wire logic        push_stb,
  input  wire logic [14:0] push_addr,
  // Sequencer requests
  output logic             instr_start,
  output logic [14:0]      next_pc,
  output logic [7:0]       pushes,
  output logic [14:0]      last_push
);
  logic [1:0] phase_reg;
  assign next_pc = 15'h1234;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
      instr_start <= 1'b0;
      pushes <= 8'h00;
      last_push <= 15'h0000;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      instr_start <= run && !ack_busy && phase_reg == 2'h3;
      if (push_stb) begin
        pushes <= pushes + 8'h01;
        last_push <= push_addr;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the maskable interrupt arbiter
// Assumes: Divider of 2; sequencer model issues instruction starts
// Notes:   APB master tasks plus event and instruction kicks
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import irq_arb_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        skip = 1'b0, run = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdat, prdata;
  logic [2:0]  cmd = 3'h0;
  logic [12:0] ev = 13'h0000;
  logic        pready, pslverr, busy, push_stb, pc_ld, pop, vis_stb, global_interrupt_enable, istart;
  logic [14:0] push_addr, pc_addr, next_pc, last_push;
  logic [7:0]  vis_addr, pushes;
  int          bad_count = 0, checks_done = 0;
  always #2 clk = ~clk;
  maskable_interrupt_arbiter #(.DIV(2)) maskable_interrupt_arbiter_inst (.CLK(clk), .NRST(nrst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SRC_EVENT(ev), .INSTR_START(istart),
    .SKIP_PENDING(skip), .TRAP_EXEC(cmd[0]), .RETURN_FROM_INTERRUPT_INSTR_EXEC(cmd[1]), .VIS_EXEC(cmd[2]),
    .NEXT_PC(next_pc), .ACK_BUSY(busy), .PUSH_STB(push_stb), .PUSH_ADDR(push_addr),
    .PC_LOAD_STB(pc_ld), .PC_LOAD_ADDR(pc_addr), .POP_STB(pop), .VIS_STB(vis_stb),
    .VIS_VEC_ADDR(vis_addr), .GIE_OUT(global_interrupt_enable));
  seq_model seq_model_inst (.clk(clk), .nrst(nrst), .run(run), .ack_busy(busy),
    .push_stb(push_stb), .push_addr(push_addr), .instr_start(istart), .next_pc(next_pc),
    .pushes(pushes), .last_push(last_push));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, ee});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0, ee);
    chk(rdat, e);
  endtask
  task kick(input logic [2:0] c, input logic [12:0] m);
    @(posedge clk);
    cmd <= c;
    ev <= m;
    @(posedge clk);
    cmd <= 3'h0;
    ev <= 13'h0000;
  endtask
  task vector_select_instruction(input logic [7:0] e);
    kick(3'h4, 13'h0000);
    @(negedge clk);
    chk({24'h0, vis_addr}, {24'h0, e});
  endtask
  task settle(input logic [7:0] n);
    repeat (40) @(posedge clk);
    chk({24'h0, pushes}, {24'h0, n});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(CTRL_OFS, 32'h0, 1'b0);
    rd(ENABLE_OFS, 32'h0, 1'b0);
    rd(PEND_OFS, 32'h0, 1'b0);
    rd(STATUS_OFS, 32'h0, 1'b0);
    rd(VECSEL_OFS, 32'hE0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    run <= 1'b1;
    kick(3'h0, 13'h1FFF);
    settle(8'h00);
    rd(PEND_OFS, 32'h1FFF, 1'b0);
    wr(PEND_OFS, 32'h1DF7);
    wr(ENABLE_OFS, 32'h0208);
    settle(8'h00);
    skip <= 1'b1;
    wr(CTRL_OFS, 32'h1);
    settle(8'h00);
    rd(STATUS_OFS, 32'h1, 1'b0);
    skip <= 1'b0;
    settle(8'h01);
    chk({17'h0, last_push}, 32'h1234);
    chk({17'h0, pc_addr}, 32'h0000_00FF);
    rd(CTRL_OFS, 32'h0, 1'b0);
    vector_select_instruction(8'hF6);
    wr(PEND_OFS, 32'h0008);
    kick(3'h0, 13'h0008);
    wr(CTRL_OFS, 32'h1);
    settle(8'h02);
    wr(PEND_OFS, 32'h0008);
    kick(3'h2, 13'h0000);
    settle(8'h03);
    vector_select_instruction(8'hEA);
    wr(PEND_OFS, 32'h0200);
    kick(3'h0, 13'h0200);
    kick(3'h2, 13'h0000);
    settle(8'h04);
    wr(PEND_OFS, 32'h0200);
    wr(ENABLE_OFS, 32'h0);
    vector_select_instruction(8'hE0);
    kick(3'h2, 13'h0000);
    rd(CTRL_OFS, 32'h1, 1'b0);
    chk({31'h0, global_interrupt_enable}, 32'h1);
    wr(CTRL_OFS, 32'h0);
    wr(ENABLE_OFS, 32'h1);
    kick(3'h1, 13'h0001);
    settle(8'h05);
    vector_select_instruction(8'hFE);
    wr(CTRL_OFS, 32'h1);
    settle(8'h05);
    kick(3'h2, 13'h0000);
    settle(8'h06);
    wr(PEND_OFS, 32'h1);
    for (int i = 0; i < NUM_SRC; i++) begin
      wr(ENABLE_OFS, 32'h1 << i);
      kick(3'h0, 13'h0001 << i);
      vector_select_instruction(8'hFC - 8'(2 * i));
      wr(PEND_OFS, 32'h1 << i);
    end
    settle(8'h06);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
